/* File: rtl/sfpsc_pkg.sv */
// Shared constants, types and helpers of the serial flash program engine
package sfpsc_pkg;

  // Command opcodes
  localparam logic [7:0] CMD_BUF_LOAD   = 8'h84;
  localparam logic [7:0] CMD_PROG_ERASE = 8'h83;
  localparam logic [7:0] CMD_PROG_ONLY  = 8'h88;
  localparam logic [7:0] CMD_PAGE_WIPE  = 8'h81;
  localparam logic [7:0] CMD_BLOCK_WIPE = 8'h50;
  localparam logic [7:0] CMD_LOAD_PROG  = 8'h82;
  localparam logic [7:0] CMD_REWRITE    = 8'h58;
  localparam logic [7:0] CMD_STATUS     = 8'h57;

  // Frame layout, in bits counted from chip select falling
  localparam logic [5:0] OPC_LAST_BIT  = 6'h07;
  localparam logic [5:0] ADDR_LAST_BIT = 6'h1F;
  localparam logic [5:0] HDR_BITS      = 6'h20;
  localparam int         PAGE_LSB      = 9;
  localparam int         PAGE_MSB      = 17;

  // Array geometry
  localparam int         PAGE_BYTES   = 264;
  localparam logic [8:0] LAST_BYTE    = 9'h107;
  localparam logic [2:0] BLOCK_LAST   = 3'h7;
  localparam int         PROT_PAGE_BIT = 8;    // Pages below 256
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;

  // Status byte layout
  localparam int         ST_READY   = 7;
  localparam int         ST_COMP    = 6;
  localparam logic [2:0] ST_RSVD    = 3'h0;

  // Self-timed operation maxima in ms
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned ERASE_WRITE_MS  = 20;
  localparam int unsigned WRITE_ONLY_MS   = 15;
  localparam int unsigned PAGE_WIPE_MS    = 10;
  localparam int unsigned BLOCK_WIPE_MS   = 15;
  localparam int          TMR_W           = 20;
  localparam int unsigned ERASE_WRITE_CYC = ERASE_WRITE_MS * (CLK_HZ/MS_PER_S);
  localparam int unsigned WRITE_ONLY_CYC  = WRITE_ONLY_MS * (CLK_HZ/MS_PER_S);
  localparam int unsigned PAGE_WIPE_CYC   = PAGE_WIPE_MS * (CLK_HZ/MS_PER_S);
  localparam int unsigned BLOCK_WIPE_CYC  = BLOCK_WIPE_MS * (CLK_HZ/MS_PER_S);

  // Sequencer states
  typedef enum logic [2:0] {
    SFPSC_IDLE,
    SFPSC_FETCH,
    SFPSC_CATCH,
    SFPSC_ERASE,
    SFPSC_PROG,
    SFPSC_WAIT
  } sfpsc_state_t;

  // Buffer byte index with wraparound after the last byte
  function automatic logic [8:0] sfpsc_next_byte(input logic [8:0] idx);
    sfpsc_next_byte = (idx == LAST_BYTE) ? 9'h000 : idx + 9'h001;
  endfunction : sfpsc_next_byte

endpackage : sfpsc_pkg

/* File: rtl/sfpsc_sync.sv */
// Two-flop level synchroniser, one bit per lane
`timescale 1ns/1ps
module sfpsc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Level in and synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sfpsc_sync_st_t;

  sfpsc_sync_st_t st_q;
  sfpsc_sync_st_t st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d        = st_q;
    st_d.meta   = d;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.stable;

endmodule : sfpsc_sync

/* File: rtl/sfpsc_link.sv */
// Serial slave front end running on the link clock
`timescale 1ns/1ps
module sfpsc_link
  import sfpsc_pkg::*;
(
  // Link pins
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       si,
  output logic            so,
  output logic            so_oe,
  // Device reset
  input  wire logic       reset_n,
  // Status from the core domain
  input  wire logic [7:0] status_byte,
  input  wire logic       ready_live,
  // Frame results, held while the link is quiet
  output logic [7:0]      cmd,
  output logic [23:0]     addr,
  output logic            hdr_done,
  output logic [8:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic            wr_toggle
);

  // Values that must survive chip select rising
  typedef struct packed {
    logic [7:0]  cmd;
    logic [23:0] adr;
    logic        done;
    logic [8:0]  wptr;
    logic [8:0]  waddr;
    logic [7:0]  wdata;
    logic        wtgl;
  } sfpsc_keep_t;

  // Per-frame state, cleared while chip select is high
  typedef struct packed {
    logic [5:0] cnt;
    logic [7:0] sh;
    logic [2:0] bcnt;
    logic       stat;
    logic       wr_on;
  } sfpsc_frame_t;

  // Output side, updated on falling edges
  typedef struct packed {
    logic [7:0] st1;
    logic [7:0] st2;
    logic [2:0] idx;
    logic       so;
    logic       oe;
    logic       live7;
  } sfpsc_fall_t;

  sfpsc_keep_t  keep_q, keep_d;
  sfpsc_frame_t frame_q, frame_d;
  sfpsc_fall_t  fall_q, fall_d;
  logic         frame_rst_n;
  logic [7:0]   nb;

  // Raising chip select ends the frame and floats SO at once
  assign frame_rst_n = reset_n & ~cs_n;
  assign nb          = {frame_q.sh[6:0], si};

  // Rising edge: shift in opcode, address and data MSB first
  always_comb begin
    keep_d     = keep_q;
    frame_d    = frame_q;
    frame_d.sh = nb;
    if (frame_q.cnt < HDR_BITS) begin
      frame_d.cnt = frame_q.cnt + 6'h01;
      if (frame_q.cnt == 6'h00) begin
        keep_d.done = 1'b0;
      end
      if (frame_q.cnt == OPC_LAST_BIT) begin
        keep_d.cmd   = nb;
        frame_d.stat = (nb == CMD_STATUS);
      end else if (frame_q.cnt > OPC_LAST_BIT) begin
        keep_d.adr = {keep_q.adr[22:0], si};
        if (frame_q.cnt == ADDR_LAST_BIT) begin
          keep_d.done = 1'b1;
          // Both load commands start at the low nine address bits
          if (keep_q.cmd == CMD_BUF_LOAD ||
              keep_q.cmd == CMD_LOAD_PROG) begin
            frame_d.wr_on = 1'b1;
            keep_d.wptr   = {keep_q.adr[7:0], si};
          end
        end
      end
    end else if (frame_q.wr_on) begin
      frame_d.bcnt = frame_q.bcnt + 3'h1;
      if (frame_q.bcnt == 3'h7) begin
        keep_d.wdata = nb;
        keep_d.waddr = keep_q.wptr;
        keep_d.wptr  = sfpsc_next_byte(keep_q.wptr);
        keep_d.wtgl  = ~keep_q.wtgl;
      end
    end
  end

  // Falling edge: status byte MSB first, repeating every eight clocks
  always_comb begin
    fall_d     = fall_q;
    fall_d.st1 = status_byte;
    fall_d.st2 = fall_q.st1;
    if (frame_q.stat) begin
      fall_d.oe    = 1'b1;
      fall_d.so    = fall_q.st2[3'h7 - fall_q.idx];
      fall_d.idx   = fall_q.idx + 3'h1;
      fall_d.live7 = (fall_q.idx == 3'h0);
    end
  end

  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      keep_q <= '0;
    end else begin
      keep_q <= keep_d;
    end
  end

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      frame_q <= '0;
    end else begin
      frame_q <= frame_d;
    end
  end

  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fall_q <= '0;
    end else begin
      fall_q <= fall_d;
    end
  end

  // Bit 7 tracks the live ready flag so a parked clock still sees it
  assign so        = fall_q.live7 ? ready_live : fall_q.so;
  assign so_oe     = fall_q.oe;
  assign cmd       = keep_q.cmd;
  assign addr      = keep_q.adr;
  assign hdr_done  = keep_q.done;
  assign wr_addr   = keep_q.waddr;
  assign wr_data   = keep_q.wdata;
  assign wr_toggle = keep_q.wtgl;

endmodule : sfpsc_link

/* File: rtl/sfpsc_top.sv */
// Command engine of a serial page flash: buffer, program, erase, status
`timescale 1ns/1ps
module sfpsc_top
  import sfpsc_pkg::*;
#(
  parameter logic [TMR_W-1:0] ERASE_AND_WRITE_CYC = TMR_W'(ERASE_WRITE_CYC),
  parameter logic [TMR_W-1:0] WRITE_ONLY_TIME_CYC = TMR_W'(WRITE_ONLY_CYC),
  parameter logic [TMR_W-1:0] PAGE_WIPE_TIME_CYC  = TMR_W'(PAGE_WIPE_CYC),
  parameter logic [TMR_W-1:0] BLOCK_WIPE_TIME_CYC = TMR_W'(BLOCK_WIPE_CYC),
  // Density code, value arbitrary
  parameter logic [2:0]       DENSITY_CODE        = 3'h5
) (
  // Core clock and device reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Serial link
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       si,
  output logic            so,
  output logic            so_oe,
  // Protect input and ready/busy open-drain pin
  input  wire logic       wp_n,
  output logic            rdy_busy_out,
  output logic            rdy_busy_oe,
  // Mode picked at the last select falling edge
  output logic            spi_mode3,
  // Main array port, read data one cycle after the read strobe
  output logic [8:0]      arr_page,
  output logic [8:0]      arr_byte,
  output logic            arr_we,
  output logic            arr_re,
  output logic [7:0]      arr_wdata,
  input  wire logic [7:0] arr_rdata
);

  typedef struct packed {
    sfpsc_state_t               st;
    logic [PAGE_BYTES-1:0][7:0] mem;
    logic [8:0]                 page;
    logic [8:0]                 byt;
    logic [2:0]                 pcnt;
    logic [2:0]                 plast;
    logic [TMR_W-1:0]           tmr;
    logic                       do_erase;
    logic                       do_prog;
    logic                       rd_wait;
    logic                       cs_prev;
    logic                       tgl_prev;
    logic                       mode3;
    logic                       comp;
    logic                       ready;
    logic                       od_oe;
    logic                       od_out;
    logic [8:0]                 a_page;
    logic [8:0]                 a_byte;
    logic                       a_we;
    logic                       a_re;
    logic [7:0]                 a_wdata;
  } sfpsc_core_t;

  sfpsc_core_t c_q;
  sfpsc_core_t c_d;

  logic [7:0]  l_cmd;
  logic [23:0] l_addr;
  logic        l_done;
  logic [8:0]  l_waddr;
  logic [7:0]  l_wdata;
  logic        l_wtgl;
  logic [3:0]  sync_in;
  logic [3:0]  sync_out;
  logic        cs_s;
  logic        sck_s;
  logic        tgl_s;
  logic        wp_s;
  logic [7:0]  status_byte;
  logic [8:0]  l_page;

  // Serial front end on the link clock
  sfpsc_link u_link (
    .sck         (sck),
    .cs_n        (cs_n),
    .si          (si),
    .so          (so),
    .so_oe       (so_oe),
    .reset_n     (reset_n),
    .status_byte (status_byte),
    .ready_live  (c_q.ready),
    .cmd         (l_cmd),
    .addr        (l_addr),
    .hdr_done    (l_done),
    .wr_addr     (l_waddr),
    .wr_data     (l_wdata),
    .wr_toggle   (l_wtgl)
  );

  // Pins and link toggle brought into the core domain; select goes in
  // inverted so the cleared synchroniser reads deselected, and no false
  // select edge follows reset
  assign sync_in = {~cs_n, sck, l_wtgl, wp_n};
  sfpsc_sync #(.W(4)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (sync_in),
    .q       (sync_out)
  );
  assign cs_s  = ~sync_out[3];
  assign sck_s = sync_out[2];
  assign tgl_s = sync_out[1];
  assign wp_s  = sync_out[0];

  // Status byte: ready, compare result, density, reserved
  // Compare result stays clear; compare itself lives elsewhere
  assign status_byte = {c_q.ready, c_q.comp,
                        DENSITY_CODE, ST_RSVD};
  assign l_page      = l_addr[PAGE_MSB:PAGE_LSB];

  // Command decode, buffer loading and the self-timed sequencer
  always_comb begin
    c_d          = c_q;
    c_d.cs_prev  = cs_s;
    c_d.tgl_prev = tgl_s;
    c_d.a_we     = 1'b0;
    c_d.a_re     = 1'b0;
    c_d.od_out   = 1'b0;
    // Idle clock level at select falling picks the mode
    if (c_q.cs_prev && !cs_s) begin
      c_d.mode3 = sck_s;
    end
    if (c_q.tmr != '0) begin
      c_d.tmr = c_q.tmr - TMR_W'(1);
    end
    case (c_q.st)
      SFPSC_IDLE: begin
        // Link holds address and data steady until the next byte lands
        if (tgl_s != c_q.tgl_prev) begin
          c_d.mem[l_waddr] = l_wdata;
        end
        // Job starts when select rises after a full header
        if (!c_q.cs_prev && cs_s && l_done) begin
          c_d.page     = l_page;
          c_d.byt      = 9'h000;
          c_d.pcnt     = 3'h0;
          c_d.plast    = 3'h0;
          c_d.do_erase = 1'b1;
          c_d.do_prog  = 1'b1;
          if (!wp_s && !l_page[PROT_PAGE_BIT]) begin
            c_d.st = SFPSC_IDLE;
          end else begin
            case (l_cmd)
              CMD_PROG_ERASE, CMD_LOAD_PROG: begin
                c_d.st  = SFPSC_ERASE;
                c_d.tmr = ERASE_AND_WRITE_CYC;
              end
              CMD_PROG_ONLY: begin
                c_d.do_erase = 1'b0;
                c_d.st       = SFPSC_PROG;
                c_d.tmr      = WRITE_ONLY_TIME_CYC;
              end
              CMD_PAGE_WIPE: begin
                c_d.do_prog = 1'b0;
                c_d.st      = SFPSC_ERASE;
                c_d.tmr     = PAGE_WIPE_TIME_CYC;
              end
              CMD_BLOCK_WIPE: begin
                c_d.do_prog = 1'b0;
                c_d.page    = {l_page[8:3], 3'h0};
                c_d.plast   = BLOCK_LAST;
                c_d.st      = SFPSC_ERASE;
                c_d.tmr     = BLOCK_WIPE_TIME_CYC;
              end
              CMD_REWRITE: begin
                c_d.st  = SFPSC_FETCH;
                c_d.tmr = ERASE_AND_WRITE_CYC;
              end
              default: begin
                c_d.st = SFPSC_IDLE;
              end
            endcase
          end
        end
      end
      SFPSC_FETCH: begin
        c_d.a_re   = 1'b1;
        c_d.a_page = c_q.page;
        c_d.a_byte = c_q.byt;
        c_d.st     = SFPSC_CATCH;
      end
      SFPSC_CATCH: begin
        // Strobe stands on the port now; its data stands one cycle later
        c_d.rd_wait = ~c_q.rd_wait;
        if (c_q.rd_wait) begin
          c_d.mem[c_q.byt] = arr_rdata;
          c_d.byt          = sfpsc_next_byte(c_q.byt);
          c_d.st = (c_q.byt == LAST_BYTE) ? SFPSC_ERASE : SFPSC_FETCH;
        end
      end
      SFPSC_ERASE: begin
        c_d.a_we    = 1'b1;
        c_d.a_page  = c_q.page | {6'h00, c_q.pcnt};
        c_d.a_byte  = c_q.byt;
        c_d.a_wdata = ERASED_BYTE;
        c_d.byt     = sfpsc_next_byte(c_q.byt);
        if (c_q.byt == LAST_BYTE) begin
          c_d.pcnt = c_q.pcnt + 3'h1;
          if (c_q.pcnt == c_q.plast) begin
            c_d.pcnt = 3'h0;
            c_d.st   = c_q.do_prog ? SFPSC_PROG : SFPSC_WAIT;
          end
        end
      end
      SFPSC_PROG: begin
        c_d.a_we    = 1'b1;
        c_d.a_page  = c_q.page;
        c_d.a_byte  = c_q.byt;
        c_d.a_wdata = c_q.mem[c_q.byt];
        c_d.byt     = sfpsc_next_byte(c_q.byt);
        if (c_q.byt == LAST_BYTE) begin
          c_d.st = SFPSC_WAIT;
        end
      end
      SFPSC_WAIT: begin
        if (c_q.tmr == '0) begin
          c_d.st = SFPSC_IDLE;
        end
      end
      default: begin
        c_d.st = SFPSC_IDLE;
      end
    endcase
    // Loads and new commands arriving while busy are dropped
    c_d.ready = (c_d.st == SFPSC_IDLE);
    c_d.od_oe = (c_d.st != SFPSC_IDLE);
  end

  // Reset aborts any job; idle, ready and mode 3 afterwards
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      c_q       <= '0;
      c_q.st    <= SFPSC_IDLE;
      c_q.mode3 <= 1'b1;
      c_q.ready <= 1'b1;
      c_q.cs_prev <= 1'b1;
    end else begin
      c_q <= c_d;
    end
  end

  // Open-drain pin: value fixed low, the enable does the signalling
  assign rdy_busy_out = c_q.od_out;
  assign rdy_busy_oe  = c_q.od_oe;
  assign spi_mode3    = c_q.mode3;
  assign arr_page     = c_q.a_page;
  assign arr_byte     = c_q.a_byte;
  assign arr_we       = c_q.a_we;
  assign arr_re       = c_q.a_re;
  assign arr_wdata    = c_q.a_wdata;

endmodule : sfpsc_top

/* File: sim/sfpsc_properties.sv */
// Port checks of the flash program engine
`timescale 1ns/1ps
module sfpsc_properties
  import sfpsc_pkg::*;
#(
  parameter logic [TMR_W-1:0] ERASE_AND_WRITE_CYC = 20'h00BB8,
  parameter logic [TMR_W-1:0] PAGE_WIPE_TIME_CYC  = 20'h004B0
) (
  // Core clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Link and protect pins
  input wire logic       cs_n,
  input wire logic       wp_n,
  input wire logic       so_oe,
  input wire logic       rdy_busy_out,
  input wire logic       rdy_busy_oe,
  input wire logic       spi_mode3,
  // Array port
  input wire logic [8:0] arr_page,
  input wire logic [8:0] arr_byte,
  input wire logic       arr_we,
  input wire logic       arr_re
);
  // Slack covers the select-to-busy latency and the sampling edge
  localparam int MIN_B = int'(PAGE_WIPE_TIME_CYC) - 4;
  localparam int MAX_B = int'(ERASE_AND_WRITE_CYC) + 8;
  logic [20:0] busy_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Length of the current busy stretch
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) busy_q <= '0;
    else busy_q <= rdy_busy_oe ? busy_q + 21'h1 : '0;
  end

  busy_pin_a: assert property (rdy_busy_oe |-> !rdy_busy_out)
    else $error("busy pin not pulled low");
  busy_start_a: assert property ($rose(rdy_busy_oe) |-> cs_n && $past(cs_n))
    else $error("busy began inside a frame");
  write_busy_a: assert property (arr_we |-> rdy_busy_oe)
    else $error("array write while ready");
  read_busy_a: assert property (arr_re |-> rdy_busy_oe && !arr_we)
    else $error("array read outside a job");
  byte_range_a: assert property (arr_we |-> arr_byte <= LAST_BYTE)
    else $error("array byte past page end");
  protect_a: assert property (arr_we && !wp_n |-> arr_page[PROT_PAGE_BIT])
    else $error("protected page written");
  busy_max_a: assert property (busy_q <= 21'(MAX_B))
    else $error("busy too long");
  busy_min_a: assert property ($fell(rdy_busy_oe) |-> busy_q >= 21'(MIN_B))
    else $error("busy too short");
  so_float_a: assert property (cs_n && $past(cs_n) |-> !so_oe)
    else $error("so driven while deselected");
  reset_idle_a: assert property ($rose(reset_n) |-> spi_mode3 && !rdy_busy_oe)
    else $error("not idle after reset");

  cover property ($fell(rdy_busy_oe));
  cover property (arr_re);
  cover property ($fell(spi_mode3));
endmodule : sfpsc_properties

/* File: sim/sfpsc_array_model.sv */
// Main flash array behind the engine's array port
`timescale 1ns/1ps
module sfpsc_array_model (
  // Core clock
  input  wire logic       clk,
  // Array port
  input  wire logic [8:0] arr_page,
  input  wire logic [8:0] arr_byte,
  input  wire logic       arr_we,
  input  wire logic       arr_re,
  input  wire logic [7:0] arr_wdata,
  output logic      [7:0] arr_rdata
);
  logic [7:0] mem [512][264];

  // Preload a per-location pattern so copies can be told apart
  initial begin
    for (int p = 0; p < 512; p++) begin
      for (int b = 0; b < 264; b++) mem[p][b] = 8'(p ^ b ^ 8'h3C);
    end
  end

  // Data a cycle after the strobe, scrambled otherwise so stale reads show
  always @(posedge clk) begin
    if (arr_we) mem[arr_page][arr_byte] <= arr_wdata;
    arr_rdata <= arr_re ? mem[arr_page][arr_byte] : ~arr_rdata;
  end
endmodule : sfpsc_array_model

/* File: sim/sfpsc_top_tb.sv */
// Self-checking bench of the flash program engine
`timescale 1ns/1ps
module sfpsc_top_tb;
  import sfpsc_pkg::*;
  // Short job times keep the run small; SCK runs at a 15 ns period
  localparam logic [TMR_W-1:0] EW = 20'h00BB8;
  localparam logic [TMR_W-1:0] WO = 20'h005DC;
  localparam logic [TMR_W-1:0] PW = 20'h004B0;
  localparam logic [TMR_W-1:0] BW = 20'h00A28;
  localparam logic [2:0]       DENS = 3'h5;
  localparam realtime          HS = 7.5;
  logic       clk, reset_n, sck, cs_n, si, wp_n, mode3;
  logic       so, so_oe, rdy_busy_out, rdy_busy_oe, spi_mode3;
  logic [8:0] arr_page, arr_byte;
  logic       arr_we, arr_re;
  logic [7:0] arr_wdata, arr_rdata, rd, s0, s1;
  logic [7:0] dq[$];
  logic [7:0] none[$];
  int         error_cnt, check_count, n;

  sfpsc_top #(
    .ERASE_AND_WRITE_CYC(EW), .WRITE_ONLY_TIME_CYC(WO),
    .PAGE_WIPE_TIME_CYC(PW), .BLOCK_WIPE_TIME_CYC(BW), .DENSITY_CODE(DENS)
  ) i_sfpsc_top (
    .clk, .reset_n, .sck, .cs_n, .si, .so, .so_oe, .wp_n, .rdy_busy_out,
    .rdy_busy_oe, .spi_mode3, .arr_page, .arr_byte, .arr_we, .arr_re,
    .arr_wdata, .arr_rdata
  );
  sfpsc_array_model i_sfpsc_array_model (
    .clk, .arr_page, .arr_byte, .arr_we, .arr_re, .arr_wdata, .arr_rdata
  );

  // Core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string what);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, g, e);
    end
  endtask : chk

  task automatic mchk(input int p, input int b, input logic [7:0] e);
    chk(i_sfpsc_array_model.mem[p][b], e, "array byte");
  endtask : mchk

  function automatic logic [7:0] pat(input int p, input int b);
    return 8'(p ^ b ^ 8'h3C);
  endfunction : pat

  // One byte MSB first; SO is taken on the rising edge
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = b[i];
      #HS sck = 1'b1;
      r[i] = so;
      #HS;
    end
  endtask : xfer

  // Idle SCK level at select falling picks the mode; it is held over a
  // core clock on both sides so the synchronised sample sees it
  task automatic open_frame();
    sck = mode3;
    #30 cs_n = 1'b0;
    #30;
  endtask : open_frame

  task automatic head(input logic [7:0] op, input logic [23:0] a);
    open_frame();
    xfer(op, rd);
    xfer(a[23:16], rd);
    xfer(a[15:8], rd);
    xfer(a[7:0], rd);
  endtask : head

  // Host lets SI go to a changed level once deselected
  task automatic close_frame();
    #HS cs_n = 1'b1;
    si = ~si;
  endtask : close_frame

  // Job frame, then count the cycles the busy pin is held
  task automatic run_job(input logic [7:0] op, input logic [23:0] a,
                         input logic [7:0] d[$]);
    head(op, a);
    foreach (d[i]) xfer(d[i], rd);
    close_frame();
    n = 0;
    repeat (10) if (rdy_busy_oe !== 1'b1) @(posedge clk);
    while (rdy_busy_oe === 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    #300;
  endtask : run_job

  task automatic busy_len(input int p);
    chk(32'(n >= p - 4 && n <= p + 4), 32'h1, "busy length");
  endtask : busy_len

  // Status byte twice in one frame
  task automatic read_status();
    open_frame();
    xfer(CMD_STATUS, rd);
    xfer(8'h00, s0);
    xfer(8'h00, s1);
    close_frame();
    #300;
  endtask : read_status

  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // Cuts a hang short
  initial begin
    #1_500_000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    error_cnt = 0;
    check_count = 0;
    reset_n = 1'b0;
    sck = 1'b1;
    cs_n = 1'b1;
    si = 1'b0;
    wp_n = 1'b1;
    mode3 = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(so_oe, 0, "so idle");
    chk(spi_mode3, 1, "reset mode");
    read_status();
    chk(spi_mode3, 0, "mode 0 pick");
    chk(s0[7:3], {2'h2, DENS}, "status");
    chk(s1[7:3], {2'h2, DENS}, "status repeat");
    mode3 = 1'b1;
    dq = '{8'hB1, 8'hB2, 8'hB3, 8'hB4};
    run_job(CMD_BUF_LOAD, 24'h000106, dq);
    chk(n, 0, "load busy");
    run_job(CMD_PROG_ERASE, {6'h00, 9'h12C, 9'h000}, none);
    busy_len(int'(EW));
    mchk(300, 262, 8'hB1);
    mchk(300, 263, 8'hB2);
    mchk(300, 0, 8'hB3);
    mchk(300, 2, 8'h00);
    dq = '{8'hA5, 8'h5A};
    run_job(CMD_LOAD_PROG, {6'h00, 9'h12D, 9'h000}, dq);
    busy_len(int'(EW));
    mchk(301, 1, 8'h5A);
    mchk(301, 263, 8'hB2);
    run_job(CMD_PAGE_WIPE, {6'h00, 9'h12E, 9'h000}, none);
    busy_len(int'(PW));
    mchk(302, 7, 8'hFF);
    run_job(CMD_PROG_ONLY, {6'h00, 9'h12E, 9'h000}, none);
    busy_len(int'(WO));
    mchk(302, 0, 8'hA5);
    mchk(302, 7, 8'h00);
    run_job(CMD_BLOCK_WIPE, {6'h00, 6'h3E, 3'h7, 9'h000}, none);
    busy_len(int'(BW));
    mchk(496, 0, 8'hFF);
    mchk(503, 263, 8'hFF);
    mchk(504, 0, pat(504, 0));
    run_job(CMD_REWRITE, {6'h00, 9'h00A, 9'h000}, none);
    busy_len(int'(EW));
    mchk(10, 7, pat(10, 7));
    run_job(CMD_PAGE_WIPE, {6'h00, 9'h12E, 9'h000}, none);
    busy_len(int'(PW));
    run_job(CMD_PROG_ONLY, {6'h00, 9'h12E, 9'h000}, none);
    mchk(302, 7, pat(10, 7));
    @(posedge clk) wp_n <= 1'b0;
    repeat (4) @(posedge clk);
    run_job(CMD_PAGE_WIPE, {6'h00, 9'h0FF, 9'h000}, none);
    chk(n, 0, "protected busy");
    mchk(255, 0, pat(255, 0));
    run_job(CMD_PAGE_WIPE, {6'h00, 9'h100, 9'h000}, none);
    mchk(256, 0, 8'hFF);
    @(posedge clk) wp_n <= 1'b1;
    head(CMD_PAGE_WIPE, {6'h00, 9'h190, 9'h000});
    close_frame();
    #300;
    run_job(CMD_PAGE_WIPE, {6'h00, 9'h191, 9'h000}, none);
    mchk(401, 0, pat(401, 0));
    mchk(400, 0, 8'hFF);
    head(CMD_PAGE_WIPE, {6'h00, 9'h193, 9'h000});
    close_frame();
    #300;
    open_frame();
    xfer(CMD_STATUS, rd);
    sck = 1'b0;
    #HS sck = 1'b1;
    chk(so, 0, "busy bit");
    n = 0;
    while (rdy_busy_oe === 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
    #1 chk(so, 1, "live ready");
    close_frame();
    #300;
    mode3 = 1'b0;
    head(CMD_PROG_ERASE, {6'h00, 9'h194, 9'h000});
    close_frame();
    repeat (50) @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    #1 chk(rdy_busy_oe, 0, "reset abort");
    chk(spi_mode3, 1, "reset mode");
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    mode3 = 1'b1;
    read_status();
    chk(s0[7], 1, "ready after reset");
    print_verdict();
  end
endmodule : sfpsc_top_tb

bind sfpsc_top sfpsc_properties #(
  .ERASE_AND_WRITE_CYC(ERASE_AND_WRITE_CYC),
  .PAGE_WIPE_TIME_CYC(PAGE_WIPE_TIME_CYC)
) i_sfpsc_properties (
  .clk, .reset_n, .cs_n, .wp_n, .so_oe, .rdy_busy_out, .rdy_busy_oe,
  .spi_mode3, .arr_page, .arr_byte, .arr_we, .arr_re
);
